// ===== src/trap_nmi_interrupt_enable.sv
/*
 * interrupt/trap control register, enable flags, trap and nmi response sequencing.
 * assumes the cpu sequencer gives one-cycle strobes on mclk and obeys the
 * acknowledge and vector outputs; register access is the cpu internal i/o port.
 * the flag pair and the nmi edge catcher live in modules of their own.
 */
`timescale 1ns/100ps
`include "irq_trap_consts.svh"
module trap_nmi_interrupt_enable
    import irq_trap_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    // internal i/o port
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // sequencer strobes
    input wire logic op_enable,
    input wire logic op_disable,
    input wire logic return_from_nonmaskable_op,
    input wire logic op_ld_air,
    input wire logic undef_fetch,
    input wire logic undef_third_byte,
    input wire logic mode0_ack_cycle,
    input wire logic sample_point,
    input wire logic mcycle_end,
    input wire logic maskable_accept,
    input wire logic internal_req,
    input wire logic resp_done,
    input wire logic dma_active,
    // pins
    input wire logic nmi_n,
    input wire logic ext_req0_n,
    input wire logic ext_req1_n,
    input wire logic ext_req2_n,
    // to the cpu
    output logic nmi_ack,
    output logic trap_ack,
    output logic push_pc,
    output logic [15:0] restart_addr,
    output logic restart_load,
    output logic dma_master_enable_clr,
    output logic trap_insert_state,
    output logic cycle_insert_block,
    output logic maskable_req,
    output logic [2:0] ext_req_active,
    output logic pv_load,
    output logic pv_value,
    output logic master_int_enable,
    output logic saved_int_enable
);

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    // the control register offset needs six address bits
    if (ADDR_W < 6) begin : g_bad_width
        $error("io address too narrow for the control register");
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    // flag pair and response sequencer
    flag_if fl ();
    resp_state_t state_r;
    resp_state_t state_nxt;
    // control register fields, pin synchronisers, nmi and trap status
    logic bad_op_r;
    logic fetch_byte_position_r;
    logic [2:0] ext_mask_r;
    logic [2:0] req_sync1_r;
    logic [2:0] req_sync2_r;
    logic nmi_pending;
    logic nmi_taken;
    logic trap_raise;
    // decode, entry and gating wires
    logic ctl_hit;
    logic ctl_wr;
    logic ctl_rd;
    logic [7:0] ctl_value;
    logic [2:0] req_level;
    logic nmi_sample_r;
    logic take_trap;
    logic [15:0] vector_sel;
    logic any_maskable;
    logic [2:0] ext_gated;

    // ----------------------------------------
    // submodules
    // ----------------------------------------
    enable_flags u_flags (
        .mclk(mclk),
        .resetn(resetn),
        .f(fl.owner)
    );

    nmi_edge_latch u_nmi (
        .mclk(mclk),
        .resetn(resetn),
        .nmi_n(nmi_n),
        .taken(nmi_taken),
        .pending(nmi_pending)
    );

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    // the offset compare uses the full port address width
    assign ctl_hit = (io_addr == ADDR_W'(`CTRL_REG_OFFSET));
    assign ctl_wr = ctl_hit & io_wr;
    assign ctl_rd = ctl_hit & io_rd;
    // unused bits read zero
    assign ctl_value = {bad_op_r, fetch_byte_position_r, 3'b000, ext_mask_r};

    // ----------------------------------------
    // trap detection
    // ----------------------------------------
    // both normal fetches and mode-0 acknowledge fetches trap, master enable ignored
    assign trap_raise = undef_fetch | (mode0_ack_cycle & undef_fetch);

    // bad-opcode flag: set beats a software clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!resetn) bad_op_r <= 1'b0;
        else if (trap_raise) bad_op_r <= 1'b1;
        else if (ctl_wr && !io_wdata[`CTRL_BIT_BAD_OP]) bad_op_r <= 1'b0;
    end

    // which opcode byte trapped, captured with the trap
    always_ff @(posedge mclk) begin
        if (!resetn) fetch_byte_position_r <= 1'b0;
        else if (trap_raise) fetch_byte_position_r <= undef_third_byte;
    end

    // enable bits; bits 7..3 of write data are not stored here
    always_ff @(posedge mclk) begin
        // request 0 comes out of reset enabled, the other two masked
        if (!resetn) ext_mask_r <= 3'(`CTRL_RESET_VAL & `CTRL_WRITE_MASK);
        else if (ctl_wr) ext_mask_r <= io_wdata[2:0];
    end

    // ----------------------------------------
    // external request pins
    // ----------------------------------------
    // two-stage synchronisers, one per request
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            req_sync1_r <= 3'b111;
            req_sync2_r <= 3'b111;
        end else begin
            req_sync1_r <= {ext_req2_n, ext_req1_n, ext_req0_n};
            req_sync2_r <= req_sync1_r;
        end
    end

    // per-request masking, then global gate by master enable
    genvar gi;
    for (gi = 0; gi < 3; gi++) begin : g_req
        assign req_level[gi] = ~req_sync2_r[gi] & ext_mask_r[gi];
    end

    // ----------------------------------------
    // response sequencer
    // ----------------------------------------
    // nmi is checked at the sample point regardless of dma activity; a trap in the
    // same cycle wins, and the held nmi is then taken at a later machine cycle end
    assign nmi_taken = (state_r == ST_IDLE) & nmi_sample_r & mcycle_end
                       & ~trap_raise;

    always_ff @(posedge mclk) begin
        if (!resetn) nmi_sample_r <= 1'b0;
        else if (sample_point) nmi_sample_r <= nmi_pending;
        else if (nmi_taken) nmi_sample_r <= 1'b0;
    end

    // trap has priority over a pending nmi as it belongs to the current fetch
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (trap_raise) state_nxt = ST_TRAP;
                else if (nmi_taken) state_nxt = ST_NMI;
                else if (maskable_accept && fl.master_int_enable) state_nxt = ST_MASK;
            end
            ST_NMI: begin
                if (resp_done) state_nxt = ST_IDLE;
            end
            ST_TRAP: begin
                if (resp_done) state_nxt = ST_IDLE;
            end
            ST_MASK: begin
                if (resp_done) state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) state_r <= ST_IDLE;
        else state_r <= state_nxt;
    end

    // ----------------------------------------
    // flag strobes
    // ----------------------------------------
    // trap never touches the flags
    assign fl.op_enable = op_enable;
    assign fl.op_disable = op_disable;
    assign fl.return_from_nonmaskable_op = return_from_nonmaskable_op;
    assign fl.take_nmi = (state_r == ST_IDLE) & (state_nxt == ST_NMI);
    assign fl.take_maskable = (state_r == ST_IDLE) & (state_nxt == ST_MASK);

    // ----------------------------------------
    // response entry decode
    // ----------------------------------------
    // vector chosen ahead so the load and the address leave on one edge
    assign take_trap = (state_r == ST_IDLE) & (state_nxt == ST_TRAP);
    assign vector_sel = (state_nxt == ST_NMI) ? `NMI_VECTOR : `TRAP_VECTOR;
    // maskable summary, refused while master enable is low
    assign any_maskable = fl.master_int_enable & (|req_level | internal_req);
    assign ext_gated = fl.master_int_enable ? req_level : 3'b000;

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            io_rdata <= 8'h00;
            pv_load <= 1'b0;
            pv_value <= 1'b0;
        end else begin
            io_rdata <= ctl_rd ? ctl_value : 8'h00;
            pv_load <= op_ld_air;
            pv_value <= fl.saved_int_enable;
        end
    end

    // entry pulses: dma suspend and pc push on nmi, push and vector 0 on trap
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            nmi_ack <= 1'b0;
            trap_ack <= 1'b0;
            push_pc <= 1'b0;
            restart_load <= 1'b0;
            restart_addr <= 16'h0000;
            dma_master_enable_clr <= 1'b0;
        end else begin
            nmi_ack <= fl.take_nmi;
            trap_ack <= take_trap;
            dma_master_enable_clr <= fl.take_nmi;
            push_pc <= fl.take_nmi | take_trap;
            restart_load <= fl.take_nmi | take_trap;
            restart_addr <= vector_sel;
        end
    end

    // trap state marker and the cycle after it stay free of inserted cycles
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            trap_insert_state <= 1'b0;
            cycle_insert_block <= 1'b0;
        end else begin
            trap_insert_state <= (state_nxt == ST_TRAP);
            cycle_insert_block <= (state_nxt == ST_TRAP) | trap_insert_state;
        end
    end

    // maskable request summary, refused while master enable is low
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            maskable_req <= 1'b0;
            ext_req_active <= 3'b000;
            master_int_enable <= 1'b0;
            saved_int_enable <= 1'b0;
        end else begin
            maskable_req <= any_maskable;
            ext_req_active <= ext_gated;
            master_int_enable <= fl.master_int_enable;
            saved_int_enable <= fl.saved_int_enable;
        end
    end

endmodule : trap_nmi_interrupt_enable

// ===== src/irq_trap_consts.svh
/*
 * interrupt/trap control constants: register offset, bit positions, reset values, vectors.
 * assumes inclusion by bare name from design files.
 */
`ifndef IRQ_TRAP_CONSTS_SVH
`define IRQ_TRAP_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CTRL_REG_OFFSET 8'h34
`define CTRL_BIT_BAD_OP 3'd7
`define CTRL_BIT_FETCH_POS 3'd6
`define CTRL_RESET_VAL 8'h01
`define CTRL_WRITE_MASK 8'h07

// ----------------------------------------
// vectors
// ----------------------------------------
`define NMI_VECTOR 16'h0066
`define TRAP_VECTOR 16'h0000

`endif

// ===== src/irq_trap_pkg.sv
/*
 * types shared by the interrupt/trap control block.
 * assumes nothing beyond a systemverilog compiler.
 */
package irq_trap_pkg;

    // response sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_NMI = 4'b0010,
        ST_TRAP = 4'b0100,
        ST_MASK = 4'b1000
    } resp_state_t;

endpackage : irq_trap_pkg

// ===== src/flag_if.sv
/*
 * interface carrying the enable flag pair and its instruction strobes.
 * assumes one clock domain shared by both ends.
 */
`timescale 1ns/100ps
interface flag_if;
    logic op_enable;
    logic op_disable;
    logic return_from_nonmaskable_op;
    logic take_nmi;
    logic take_maskable;
    logic master_int_enable;
    logic saved_int_enable;

    modport owner (
        input op_enable, op_disable, return_from_nonmaskable_op, take_nmi, take_maskable,
        output master_int_enable, saved_int_enable
    );
    modport user (
        output op_enable, op_disable, return_from_nonmaskable_op, take_nmi, take_maskable,
        input master_int_enable, saved_int_enable
    );
endinterface : flag_if

// ===== src/enable_flags.sv
/*
 * master and saved interrupt enable flags.
 * assumes at most one strobe per cycle from the sequencer.
 */
`timescale 1ns/100ps
module enable_flags (
    input wire logic mclk,
    input wire logic resetn,
    flag_if.owner f
);
    logic master_r;
    logic saved_r;
    logic master_nxt;
    logic saved_nxt;

    // ----------------------------------------
    // next-state selection
    // ----------------------------------------
    // nmi entry saves master before clearing it
    assign master_nxt = (f.op_disable | f.take_nmi | f.take_maskable) ? 1'b0 :
                        f.op_enable ? 1'b1 :
                        f.return_from_nonmaskable_op ? saved_r : master_r;
    assign saved_nxt = (f.op_disable | f.take_maskable) ? 1'b0 :
                       f.op_enable ? 1'b1 :
                       f.take_nmi ? master_r : saved_r;

    // flag registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            master_r <= 1'b0;
            saved_r <= 1'b0;
        end else begin
            master_r <= master_nxt;
            saved_r <= saved_nxt;
        end
    end

    assign f.master_int_enable = master_r;
    assign f.saved_int_enable = saved_r;
endmodule : enable_flags

// ===== src/nmi_edge_latch.sv
/*
 * falling-edge catcher for the non-maskable pin, held until taken.
 * assumes the pin is asynchronous to mclk.
 */
`timescale 1ns/100ps
module nmi_edge_latch (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic nmi_n,
    input wire logic taken,
    output logic pending
);
    logic sync1_r;
    logic sync2_r;
    logic last_r;
    logic pend_r;
    logic fall;

    // ----------------------------------------
    // synchroniser and edge detect
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            last_r <= 1'b1;
        end else begin
            sync1_r <= nmi_n;
            sync2_r <= sync1_r;
            last_r <= sync2_r;
        end
    end

    assign fall = last_r & ~sync2_r;

    // new edge wins over the take so none is lost
    always_ff @(posedge mclk) begin
        if (!resetn) pend_r <= 1'b0;
        else pend_r <= fall | (pend_r & ~taken);
    end

    assign pending = pend_r;
endmodule : nmi_edge_latch

// ===== testbench/trap_nmi_interrupt_enable_sva.sv
/* checker: flag, trap and nmi timing on the top ports.
   assumes one mclk domain and a synchronous active-low reset. */
`timescale 1ns/100ps
module irq_trap_checker (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic op_enable,
    input wire logic op_disable,
    input wire logic return_from_nonmaskable_op,
    input wire logic op_ld_air,
    input wire logic undef_fetch,
    input wire logic maskable_accept,
    input wire logic nmi_ack,
    input wire logic trap_ack,
    input wire logic push_pc,
    input wire logic [15:0] restart_addr,
    input wire logic restart_load,
    input wire logic dma_master_enable_clr,
    input wire logic trap_insert_state,
    input wire logic cycle_insert_block,
    input wire logic maskable_req,
    input wire logic [2:0] ext_req_active,
    input wire logic pv_load,
    input wire logic pv_value,
    input wire logic master_int_enable,
    input wire logic saved_int_enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // flag outputs lag the strobe by two edges
    property p_en_op; op_enable |-> ##2 master_int_enable && saved_int_enable; endproperty
    a_en_op: assert property (p_en_op) else $error("enable op");
    property p_off_op; op_disable |-> ##2 !master_int_enable && !saved_int_enable; endproperty
    a_off_op: assert property (p_off_op) else $error("off op");
    property p_nmi_ret; return_from_nonmaskable_op |-> ##2
        master_int_enable == saved_int_enable; endproperty
    a_nmi_ret: assert property (p_nmi_ret) else $error("nmi return");
    property p_acc; maskable_accept && master_int_enable |-> ##2 !master_int_enable
        && !saved_int_enable; endproperty
    a_acc: assert property (p_acc) else $error("accept");
    property p_nmi; nmi_ack && master_int_enable |-> ##[1:3] saved_int_enable
        && !master_int_enable; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi flags");
    // three low samples guarantee the internal flag was low too
    property p_gate; !master_int_enable [*3] |-> ext_req_active == 3'h0 && !maskable_req;
    endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_trap; undef_fetch |=> trap_ack && push_pc && restart_load
        && trap_insert_state && restart_addr == 16'h0000; endproperty
    a_trap: assert property (p_trap) else $error("trap");
    property p_nresp; nmi_ack |-> push_pc && restart_load && dma_master_enable_clr
        && restart_addr == 16'h0066; endproperty
    a_nresp: assert property (p_nresp) else $error("nmi resp");
    property p_pv; op_ld_air |=> pv_load && pv_value == saved_int_enable; endproperty
    a_pv: assert property (p_pv) else $error("pv");
    // the cycle after the trap state marker is still closed to inserted cycles
    property p_ins; trap_insert_state |=> cycle_insert_block; endproperty
    a_ins: assert property (p_ins) else $error("insert block");
endmodule : irq_trap_checker

bind trap_nmi_interrupt_enable irq_trap_checker chk_i (.mclk, .resetn, .op_enable,
    .op_disable, .return_from_nonmaskable_op, .op_ld_air, .undef_fetch, .maskable_accept,
    .nmi_ack, .trap_ack, .push_pc, .restart_addr, .restart_load, .dma_master_enable_clr,
    .trap_insert_state, .cycle_insert_block, .maskable_req, .ext_req_active, .pv_load,
    .pv_value, .master_int_enable, .saved_int_enable);

// ===== testbench/irq_pins_model.sv
/* partner: external request pins and a short nmi low pulse.
   assumes fire is a one-cycle bench request on mclk. */
`timescale 1ns/100ps
module irq_pins_model (
    input wire logic mclk,
    input wire logic fire,
    input wire logic [2:0] lvl,
    output logic nmi_n,
    output logic ext_req0_n,
    output logic ext_req1_n,
    output logic ext_req2_n
);
    logic [2:0] low_r = 3'h0;
    // active-low request levels
    assign {ext_req2_n, ext_req1_n, ext_req0_n} = ~lvl;
    // pulled up again well before the cpu samples it
    assign nmi_n = (low_r == 3'h0);
    always_ff @(posedge mclk) begin
        if (fire) low_r <= 3'h4;
        else if (low_r != 3'h0) low_r <= low_r - 3'h1;
    end
endmodule : irq_pins_model

// ===== testbench/trap_nmi_interrupt_enable_tb.sv
/* bench: strobes, register cycles and pin events against a flag model.
   assumes the checker is bound from its own file. */
`timescale 1ns/100ps
module trap_nmi_interrupt_enable_tb;
    logic mclk = 0;
    logic resetn = 0;
    logic [7:0] io_addr = 0, io_wdata = 0, io_rdata, d;
    logic io_wr = 0, io_rd = 0, undef_third_byte = 0, mode0_ack_cycle = 0, internal_req = 0;
    logic dma_active = 0, fire = 0, nmi_n, ext_req0_n, ext_req1_n, ext_req2_n;
    logic [8:0] st = 0;
    logic [2:0] lvl = 0, ext_req_active;
    logic op_enable, op_disable, return_from_nonmaskable_op, op_ld_air, undef_fetch;
    logic maskable_accept;
    logic sample_point, mcycle_end, resp_done, nmi_ack, trap_ack, push_pc, restart_load;
    logic dma_master_enable_clr, trap_insert_state, cycle_insert_block, maskable_req;
    logic pv_load, pv_value, master_int_enable, saved_int_enable;
    logic [15:0] restart_addr;
    int errors = 0, checks_done = 0, seed = 32'h0c9340f6, m1 = 0, s2 = 0, ite = 1, fpos = 0;
    int trp = 0, n;
    // one-hot strobe word, so only one strobe per cycle
    assign {resp_done, mcycle_end, sample_point, maskable_accept, undef_fetch, op_ld_air,
        return_from_nonmaskable_op, op_disable, op_enable} = st;
    initial forever #12.5 mclk = ~mclk;
    trap_nmi_interrupt_enable dut (.mclk, .resetn, .io_addr, .io_wr, .io_rd, .io_wdata,
        .io_rdata, .op_enable, .op_disable, .return_from_nonmaskable_op, .op_ld_air, .undef_fetch,
        .undef_third_byte, .mode0_ack_cycle, .sample_point, .mcycle_end, .maskable_accept,
        .internal_req, .resp_done, .dma_active, .nmi_n, .ext_req0_n, .ext_req1_n,
        .ext_req2_n, .nmi_ack, .trap_ack, .push_pc, .restart_addr, .restart_load,
        .dma_master_enable_clr, .trap_insert_state, .cycle_insert_block, .maskable_req,
        .ext_req_active, .pv_load, .pv_value, .master_int_enable, .saved_int_enable);
    irq_pins_model pins (.mclk, .fire, .lvl, .nmi_n, .ext_req0_n, .ext_req1_n, .ext_req2_n);

    task conclude;
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] ctl_val();
        return {trp[0], fpos[0], 3'h0, ite[2:0]};
    endfunction : ctl_val
    // every task except chk and conclude starts and ends on a rising edge
    task pulse(input int b);
        st <= 9'h1 << b;
        @(posedge mclk) st <= 9'h0;
        @(posedge mclk);
    endtask : pulse
    task flags;
        #1 chk({master_int_enable, saved_int_enable}, {m1[0], s2[0]});
        @(posedge mclk);
    endtask : flags
    task op(input int b);
        case (b)
            0: begin m1 = 1; s2 = 1; end
            1: begin m1 = 0; s2 = 0; end
            2: m1 = s2;
            5: if (m1 != 0) begin m1 = 0; s2 = 0; end
            default: ;
        endcase
        st <= 9'h1 << b;
        @(posedge mclk) st <= 9'h0;
        // pv_load stands for this one cycle only
        #1 if (b == 3) chk({pv_load, pv_value}, {1'b1, s2[0]});
        @(posedge mclk);
        // close any maskable response so the sequencer is idle again
        if (b == 5) pulse(8);
        flags;
    endtask : op
    task wr(input logic [7:0] a, input logic [7:0] v);
        io_addr <= a;
        io_wdata <= v;
        io_wr <= 1;
        @(posedge mclk) io_wr <= 0;
        @(posedge mclk);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        io_addr <= a;
        io_rd <= 1;
        @(posedge mclk) io_rd <= 0;
        #1 chk({8'h0, io_rdata}, {8'h0, e});
        @(posedge mclk);
    endtask : rd_chk
    // bounded wait for an acknowledge, then check the response outputs
    task await(input bit t);
        n = 0;
        #1;
        while ((t ? trap_ack : nmi_ack) !== 1'b1) begin
            n++;
            if (n > 8) begin chk(n, 0); conclude; end
            @(posedge mclk) #1;
        end
        chk(restart_addr, t ? 16'h0000 : 16'h0066);
        chk({push_pc, restart_load, dma_master_enable_clr}, {2'b11, !t});
        @(posedge mclk);
        pulse(8);
        flags;
    endtask : await
    task nmi;
        fire <= 1;
        @(posedge mclk) fire <= 0;
        repeat (10) @(posedge mclk); // pin long released, latch must hold the edge
        pulse(6);
        // acknowledge registers on the edge that samples mcycle_end
        st <= 9'h1 << 7;
        @(posedge mclk) st <= 9'h0;
        s2 = m1;
        m1 = 0;
        await(0);
    endtask : nmi

    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1;
        @(posedge mclk);
        flags;
        rd_chk(8'h34, ctl_val());
        wr(8'h34, 8'hff);
        ite = 7;
        rd_chk(8'h34, ctl_val());
        wr(8'h33, 8'h00);
        rd_chk(8'h34, ctl_val());
        rd_chk(8'h35, 8'h00);
        // random masks and pin levels under both master states
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wr(8'h34, d);
            ite = d[2:0];
            op(i % 2);
            lvl <= 3'($random(seed));
            internal_req <= d[3];
            repeat (5) @(posedge mclk);
            n = (m1 != 0) ? (lvl & ite[2:0]) : 0;
            #1 chk({maskable_req, ext_req_active}, {m1[0] && (d[3] || n != 0), n[2:0]});
            @(posedge mclk);
        end
        op(5);
        op(3);
        op(0);
        op(3);
        op(5);
        op(0);
        dma_active <= 1;
        nmi;
        op(3);
        op(2);
        op(1);
        nmi;
        op(2);
        // trap taken with master off and on, third then second byte
        for (int t = 1; t >= 0; t--) begin
            op(t);
            undef_third_byte <= t[0];
            mode0_ack_cycle <= t[0];
            trp = 1;
            fpos = t;
            // trap_ack stands one cycle, so await starts on the sampling edge
            st <= 9'h1 << 4;
            @(posedge mclk) st <= 9'h0;
            await(1);
            rd_chk(8'h34, ctl_val());
            wr(8'h34, {5'h0, ite[2:0]});
            trp = 0;
            rd_chk(8'h34, ctl_val());
        end
        resetn <= 0;
        @(posedge mclk) resetn <= 1;
        m1 = 0;
        s2 = 0;
        ite = 1;
        fpos = 0;
        @(posedge mclk);
        flags;
        rd_chk(8'h34, ctl_val());
        conclude;
    end
endmodule : trap_nmi_interrupt_enable_tb
